// ---- sim/tb_top.sv ----
// Purpose: Self-checking bench for the timer over its register bus and pins.
// Assumes: Response channels are always ready; reads are checked from a queue of expected words.
// Notes: Counter timing is judged by differences so one cycle of bus latency cannot mislead it.
`timescale 1ns/10ps
module tb_top;
    logic aclk, aresetn, awvalid, wvalid, arvalid, want_a, want_b;
    logic [3:0] awaddr, araddr;
    logic [31:0] wdata, rd, rdata;
    logic awready, wready, bvalid, arready, rvalid, tin_a, tin_b, tout, oen_n, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] exp_q[$], msk_q[$];
    int fail_count, checks, cyc, t_ar, n, g, c0;
    logic o1;
    logic src_t[6] = '{1, 1, 1, 0, 0, 0};
    logic [1:0] edg_t[6] = '{tec_pkg::EDGE_RISE, tec_pkg::EDGE_FALL, tec_pkg::EDGE_BOTH,
                             tec_pkg::EDGE_FALL, tec_pkg::EDGE_RISE, tec_pkg::EDGE_BOTH};
    logic cr_t[6] = '{0, 1, 0, 0, 1, 1};
    logic cf_t[6] = '{1, 0, 0, 1, 0, 1};
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; $display("FAIL %0t mismatch", $time); end end

    tec_timer u_tec_timer (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .timer_input_a(tin_a),
        .timer_input_b(tin_b), .timer_output(tout), .timer_output_oen_n(oen_n), .match_a_interrupt(irq));
    tec_pulse_src u_tec_pulse_src (.aclk(aclk), .want_a(want_a), .want_b(want_b), .oen_n(oen_n),
        .timer_input_a(tin_a), .timer_input_b(tin_b));

    // Free-running clock and a cycle count used to time bus handshakes.
    always #5 aclk = ~aclk;
    always @(posedge aclk) cyc <= cyc + 1;

    // Every completed read is held against the oldest expected word; a zero mask means checked elsewhere.
    always @(posedge aclk) begin
        if (rvalid === 1'b1) begin
            `CHK(rresp, tec_pkg::RESP_OKAY)
            if (exp_q.size() == 0) begin
                `CHK(1'b0, 1'b1)
            end else if (msk_q[0] != 0) begin
                `CHK(rdata & msk_q[0], exp_q[0])
            end
            if (exp_q.size() != 0) begin
                void'(exp_q.pop_front());
                void'(msk_q.pop_front());
            end
        end
    end

    function automatic logic [31:0] mw(logic [1:0] run, logic [1:0] ea, logic [1:0] eb, logic oe);
        // The forbidden edge pattern 10 is never composed here.
        return {23'h0, oe, eb, ea, run, 2'h0};
    endfunction

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        int t;
        t = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            t++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && t < 200);
        if (t >= 200) begin
            fail_count++;
            conclude();
        end
        `CHK(bresp, (a == tec_pkg::OFF_COUNT) ? tec_pkg::RESP_SLVERR : tec_pkg::RESP_OKAY)
    endtask

    task automatic rdq(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m, output logic [31:0] d);
        int t;
        t = 0;
        exp_q.push_back(e);
        msk_q.push_back(m);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            t++;
            if (arvalid && arready) begin
                arvalid <= 1'b0;
                t_ar = cyc;
            end
        end while (rvalid !== 1'b1 && t < 200);
        if (t >= 200) begin
            fail_count++;
            conclude();
        end
        d = rdata;
    endtask

    task automatic gap(output int k);
        k = 0;
        do begin
            @(posedge aclk);
            k++;
        end while (irq !== 1'b1 && k < 1000);
    endtask

    task automatic conclude;
        if (fail_count == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // A hang anywhere ends the run as a failure; the tests need only a few thousand cycles.
    initial begin
        #300000;
        fail_count++;
        conclude();
    end

    // Main sequence.
    initial begin
        aclk = 1'b0; aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; arvalid = 1'b0;
        awaddr = 4'h0; araddr = 4'h0; wdata = 32'h0; want_a = 1'b0; want_b = 1'b0;
        cyc = 0; fail_count = 0; checks = 0;
        void'($urandom(32'hdc58));
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        // Reset state, and the counter ignores writes.
        `CHK(oen_n, 1'b1)
        rdq(tec_pkg::OFF_COUNT, 32'h0, 32'hffffffff, rd);
        rdq(tec_pkg::OFF_CMPA, {16'h0, tec_pkg::CMPA_RST}, 32'hffffffff, rd);
        rdq(tec_pkg::OFF_MODE, 32'h0, 32'hffffffff, rd);
        rdq(tec_pkg::OFF_CAPCTL, 32'h0, 32'hffffffff, rd);
        wr(tec_pkg::OFF_COUNT, 32'h0000ffff);
        rdq(tec_pkg::OFF_COUNT, 32'h0, 32'hffffffff, rd);
        // Free run: two snapshots differ by exactly the cycles between them.
        wr(tec_pkg::OFF_MODE, mw(tec_pkg::RUN_FREE, 2'h0, 2'h0, 1'b0));
        rdq(tec_pkg::OFF_COUNT, 32'h0, 32'h0, rd);
        c0 = t_ar;
        o1 = rd[0];
        n = rd;
        repeat ($urandom % 20) @(posedge aclk);
        rdq(tec_pkg::OFF_COUNT, 32'h0, 32'h0, rd);
        `CHK(rd[15:0], 16'(n + t_ar - c0))
        // Match-clear interval with a random compare value; output toggles each match.
        n = 3 + $urandom % 20;
        wr(tec_pkg::OFF_CMPA, 32'(n));
        wr(tec_pkg::OFF_CAPCTL, 32'h0);
        // Stop first so the count restarts below the compare value instead of wrapping through 65536.
        wr(tec_pkg::OFF_MODE, mw(tec_pkg::RUN_STOP, 2'h0, 2'h0, 1'b0));
        wr(tec_pkg::OFF_MODE, mw(tec_pkg::RUN_CLR_MATCH, 2'h0, 2'h0, 1'b1));
        `CHK(oen_n, 1'b0)
        gap(g);
        o1 = tout;
        gap(g);
        `CHK(g, n + 1)
        `CHK(tout, ~o1)
        // Stop clears the counter and silences matches.
        wr(tec_pkg::OFF_MODE, mw(tec_pkg::RUN_STOP, 2'h0, 2'h0, 1'b0));
        gap(g);
        `CHK(g, 1000)
        rdq(tec_pkg::OFF_COUNT, 32'h0, 32'hffffffff, rd);
        // Edge-clear on rising pin a; a falling edge must not clear.
        wr(tec_pkg::OFF_MODE, mw(tec_pkg::RUN_CLR_EDGE, tec_pkg::EDGE_RISE, 2'h0, 1'b0));
        repeat (60) @(posedge aclk);
        want_a <= 1'b1;
        repeat (30) @(posedge aclk);
        rdq(tec_pkg::OFF_COUNT, 32'h0, 32'h0, rd);
        `CHK(rd[15:0] > 16'd15 && rd[15:0] < 16'd30, 1'b1)
        want_a <= 1'b0;
        repeat (30) @(posedge aclk);
        rdq(tec_pkg::OFF_COUNT, 32'h0, 32'h0, rd);
        `CHK(rd[15:0] > 16'd45, 1'b1)
        // Capture source and edge table; a random marker shows whether capture happened.
        for (int i = 0; i < 6; i++) begin
            n = 16'h8000 | ($urandom % 16'h8000);
            wr(tec_pkg::OFF_MODE, mw(tec_pkg::RUN_FREE, edg_t[i], edg_t[i], 1'b0));
            wr(tec_pkg::OFF_CAPCTL, {30'h0, src_t[i], 1'b1});
            for (int s = 0; s < 2; s++) begin
                wr(tec_pkg::OFF_CMPA, 32'(n));
                if (src_t[i]) want_a <= (s == 0);
                else want_b <= (s == 0);
                repeat (40) @(posedge aclk);
                rdq(tec_pkg::OFF_CMPA, 32'h0, 32'h0, rd);
                `CHK(rd[15:0] != 16'(n), (s == 0) ? cr_t[i] : cf_t[i])
            end
        end
        conclude();
    end
endmodule

// ---- sim/tec_pulse_src.sv ----
// Purpose: Behavioural pulse source standing on both timer input pins.
// Assumes: The bench asks for a pin level; the pin follows once the old level has lasted long enough, pin a only while oen_n is high.
// Notes: Pins move off the clock edge because real sources are asynchronous.
`timescale 1ns/10ps
module tec_pulse_src #(
    parameter int MIN_HOLD = 16
) (
    input wire logic aclk, // Main clock, only used to time level widths.
    input wire logic want_a, // Requested level on pin a.
    input wire logic want_b, // Requested level on pin b.
    input wire logic oen_n, // Low while the block drives the shared pin.
    output logic timer_input_a, // Pin a.
    output logic timer_input_b // Pin b.
);
    int hold_a;
    int hold_b;

    // Pins start low with their widths already satisfied.
    initial begin
        timer_input_a = 1'b0;
        timer_input_b = 1'b0;
        hold_a = MIN_HOLD;
        hold_b = MIN_HOLD;
    end

    // A level is never cut shorter than the minimum width, so an early request simply waits.
    always @(posedge aclk) begin
        hold_a <= hold_a + 1;
        hold_b <= hold_b + 1;
        if (want_a !== timer_input_a && hold_a >= MIN_HOLD && oen_n === 1'b1) begin
            timer_input_a <= #3 want_a;
            hold_a <= 0;
        end
        if (want_b !== timer_input_b && hold_b >= MIN_HOLD) begin
            timer_input_b <= #3 want_b;
            hold_b <= 0;
        end
    end
endmodule

// ---- verilog/tec_edge_det.sv ----
// Purpose: Two-flop synchroniser with rise and fall detection for one pin.
// Assumes: Pin is asynchronous to aclk.
// Notes: The first flop feeds only the second flop.
`timescale 1ns/10ps
module tec_edge_det (
    input wire logic aclk, // System clock.
    input wire logic aresetn, // Synchronous reset, active low.
    input wire logic pin, // Raw asynchronous pin.
    tec_pin_if.src edge_o // Synchronised level and edges.
);
    logic meta_q;
    logic sync_q;
    logic last_q;

    // Two flops settle the pin, a third remembers the previous level so each edge gives one strobe.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            meta_q <= pin;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    // Strobes.
    assign edge_o.level = sync_q;
    assign edge_o.rise = sync_q & ~last_q;
    assign edge_o.fall = ~sync_q & last_q;

    edge_once_a: assert property (@(posedge aclk) disable iff (!aresetn) // R21
        edge_o.rise |=> !edge_o.rise) else $error("Rise strobe lasted two cycles.");
endmodule

// ---- verilog/tec_pin_if.sv ----
// Purpose: Carries one synchronised timer pin and its edge strobes.
// Assumes: All signals on aclk.
// Notes: Filled by the edge detector, read by the timer core.
`timescale 1ns/10ps
interface tec_pin_if;
    logic level; // Synchronised pin level.
    logic rise; // One-cycle rising edge strobe.
    logic fall; // One-cycle falling edge strobe.
    modport src (output level, rise, fall);
    modport dst (input level, rise, fall);
endinterface

// ---- verilog/tec_pkg.sv ----
// Purpose: Shared constants for the 16-bit timer/event counter.
// Assumes: 32-bit AXI4-Lite register bus, one aligned word per register.
// Notes: Register offsets are byte addresses.
package tec_pkg;
    localparam logic [3:0] OFF_COUNT = 4'h0;
    localparam logic [3:0] OFF_CMPA = 4'h4;
    localparam logic [3:0] OFF_MODE = 4'h8;
    localparam logic [3:0] OFF_CAPCTL = 4'hc;
    localparam logic [15:0] COUNT_RST = 16'h0000;
    localparam logic [15:0] CMPA_RST = 16'h0000;
    localparam logic [1:0] RUN_STOP = 2'h0;
    localparam logic [1:0] RUN_FREE = 2'h1;
    localparam logic [1:0] RUN_CLR_EDGE = 2'h2;
    localparam logic [1:0] RUN_CLR_MATCH = 2'h3;
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    localparam int MODE_RUN_LSB = 2;
    localparam int MODE_EA_LSB = 4;
    localparam int MODE_EB_LSB = 6;
    localparam int CAP_SEL_BIT = 0;
    localparam int CAP_SRC_BIT = 1;
    localparam int OUT_EN_BIT = 8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- verilog/tec_timer.sv ----
// Purpose: 16-bit timer/event counter with one capture/compare register over AXI4-Lite.
// Assumes: aclk at 100 MHz is the count clock; pins are asynchronous.
// Notes: Reads of the counter return a held snapshot.
//
// Behaviour
// R1: Read-only 16-bit counter advances each count clock.
// R2: Counter reads return a coherent held snapshot.
// R3: Reset forces the counter to zero.
// R4: Run mode 00 holds counter at zero.
// R5: Edge-clear mode zeroes counter on input_a edge.
// R6: Match-clear mode zeroes counter on compare match.
// R7: Capture select bit picks compare or capture.
// R8: Compare equality raises the match interrupt.
// R9: Compare register sets interval, 2 to 65536; the code also gives an interval of 1 with a compare value of 0.
// R10: Source select picks input_a or input_b trigger.
// R11: Input_a capture uses opposite edge; both none.
// R12: Input_b capture uses the configured edge.
// R13: Software never writes edge pattern 10.
// R14: Event pulses last sixteen main clocks.
// R15: Measured levels last two main clocks.
// R16: Square wave period is twice the count.
// R17: Pulse output width below period, period bounded.
// R18: Shared pin never input and output together.
// R19: Run mode encoding: stop, free, edge-clear, match-clear.
// R20: Capture copies the counter in the edge cycle.
// R21: Timer pins synchronised before edge detection.
`timescale 1ns/10ps
module tec_timer (
    input wire logic aclk, // System and count clock.
    input wire logic aresetn, // Synchronous reset, active low.
    input wire logic [3:0] s_axi_awaddr, // Write address.
    input wire logic s_axi_awvalid, // Write address valid.
    output logic s_axi_awready, // Write address ready.
    input wire logic [31:0] s_axi_wdata, // Write data.
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
    input wire logic s_axi_wvalid, // Write data valid.
    output logic s_axi_wready, // Write data ready.
    output logic [1:0] s_axi_bresp, // Write response.
    output logic s_axi_bvalid, // Write response valid.
    input wire logic s_axi_bready, // Write response ready.
    input wire logic [3:0] s_axi_araddr, // Read address.
    input wire logic s_axi_arvalid, // Read address valid.
    output logic s_axi_arready, // Read address ready.
    output logic [31:0] s_axi_rdata, // Read data.
    output logic [1:0] s_axi_rresp, // Read response.
    output logic s_axi_rvalid, // Read data valid.
    input wire logic s_axi_rready, // Read data ready.
    input wire logic timer_input_a, // Timer input pin a.
    input wire logic timer_input_b, // Timer input pin b.
    output logic timer_output, // Square-wave output.
    output logic timer_output_oen_n, // Output enable, low while driving.
    output logic match_a_interrupt // One-cycle match pulse.
);
    typedef enum logic [1:0] {TEC_W_IDLE = 2'b00, TEC_W_RESP = 2'b01} tec_wstate_t;

    tec_pin_if pin_a ();
    tec_pin_if pin_b ();

    logic [15:0] up_counter_q;
    logic [15:0] capture_compare_reg_a_q;
    logic [1:0] run_mode_q;
    logic [1:0] edge_a_q;
    logic [1:0] edge_b_q;
    logic out_en_q;
    logic reg_a_capture_select_q;
    logic capture_source_select_q;
    logic [15:0] snap_q;
    logic timer_output_q;
    logic match_q;
    tec_wstate_t wstate_q;
    logic aw_got_q;
    logic w_got_q;
    logic [3:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic valid_a;
    logic valid_a_cap;
    logic valid_b;
    logic trig;
    logic match;
    logic do_write;
    logic [31:0] rd_word;
    logic rd_ok;

    // Pins pass two flops before any edge logic.
    tec_edge_det u_edge_a (.aclk(aclk), .aresetn(aresetn), .pin(timer_input_a), .edge_o(pin_a)); // R21
    tec_edge_det u_edge_b (.aclk(aclk), .aresetn(aresetn), .pin(timer_input_b), .edge_o(pin_b)); // R21

    // Valid edges of input a for clearing, and the reversed phase used for capture.
    always_comb begin
        valid_a = 1'b0;
        valid_a_cap = 1'b0;
        case (edge_a_q)
            tec_pkg::EDGE_FALL: begin
                valid_a = pin_a.fall;
                valid_a_cap = pin_a.rise; // R11
            end
            tec_pkg::EDGE_RISE: begin
                valid_a = pin_a.rise;
                valid_a_cap = pin_a.fall; // R11
            end
            tec_pkg::EDGE_BOTH: begin
                valid_a = pin_a.rise | pin_a.fall;
                valid_a_cap = 1'b0; // R11
            end
            default: begin
                valid_a = 1'b0;
                valid_a_cap = 1'b0;
            end
        endcase
    end

    // Input b captures on its configured edge directly.
    always_comb begin
        case (edge_b_q)
            tec_pkg::EDGE_FALL: valid_b = pin_b.fall; // R12
            tec_pkg::EDGE_RISE: valid_b = pin_b.rise; // R12
            tec_pkg::EDGE_BOTH: valid_b = pin_b.rise | pin_b.fall; // R12
            default: valid_b = 1'b0;
        endcase
    end

    // Capture trigger selection; the reserved edge code 10 selects nothing.
    assign trig = reg_a_capture_select_q & (capture_source_select_q ? valid_a_cap : valid_b); // R10
    assign match = ~reg_a_capture_select_q && (run_mode_q != tec_pkg::RUN_STOP)
        && (up_counter_q == capture_compare_reg_a_q); // R8

    // The counter runs whenever the mode is not stop; clears take priority over counting.
    // A counter read only freezes the snapshot, so the live count never loses a clock.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            up_counter_q <= tec_pkg::COUNT_RST; // R3
        end else if (run_mode_q == tec_pkg::RUN_STOP) begin
            up_counter_q <= tec_pkg::COUNT_RST; // R4 R19
        end else if (run_mode_q == tec_pkg::RUN_CLR_EDGE && valid_a) begin
            up_counter_q <= tec_pkg::COUNT_RST; // R5
        end else if (run_mode_q == tec_pkg::RUN_CLR_MATCH && up_counter_q == capture_compare_reg_a_q) begin
            up_counter_q <= tec_pkg::COUNT_RST; // R6 R9
        end else begin
            up_counter_q <= up_counter_q + 16'h0001; // R1
        end
    end

    // Snapshot for reads: sampled when the read address is taken.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            snap_q <= tec_pkg::COUNT_RST;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                snap_q <= up_counter_q; // R2
            end
        end
    end

    // Capture/compare register: capture wins over a software write in the same cycle.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            capture_compare_reg_a_q <= tec_pkg::CMPA_RST;
        end else if (trig) begin
            capture_compare_reg_a_q <= up_counter_q; // R20 R7
        end else if (do_write && awaddr_q == tec_pkg::OFF_CMPA) begin
            if (wstrb_q[0]) capture_compare_reg_a_q[7:0] <= wdata_q[7:0];
            if (wstrb_q[1]) capture_compare_reg_a_q[15:8] <= wdata_q[15:8];
        end
    end

    // Match pulse and square-wave toggle; a period of twice the count.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            match_q <= 1'b0;
            timer_output_q <= 1'b0;
        end else begin
            match_q <= match; // R8
            if (run_mode_q == tec_pkg::RUN_STOP) begin
                timer_output_q <= timer_output_q;
            end else if (match) begin
                timer_output_q <= ~timer_output_q; // R16 R17
            end
        end
    end

    assign match_a_interrupt = match_q;
    assign timer_output = timer_output_q;
    // The pin is only driven when enabled; software must not also use it as input a.
    assign timer_output_oen_n = ~out_en_q; // R18

    // Control registers.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_mode_q <= tec_pkg::RUN_STOP;
            edge_a_q <= tec_pkg::EDGE_FALL;
            edge_b_q <= tec_pkg::EDGE_FALL;
            out_en_q <= 1'b0;
            reg_a_capture_select_q <= 1'b0;
            capture_source_select_q <= 1'b0;
        end else if (do_write) begin
            if (awaddr_q == tec_pkg::OFF_MODE) begin
                if (wstrb_q[0]) begin
                    run_mode_q <= wdata_q[tec_pkg::MODE_RUN_LSB +: 2]; // R19
                    edge_a_q <= wdata_q[tec_pkg::MODE_EA_LSB +: 2]; // R13
                    edge_b_q <= wdata_q[tec_pkg::MODE_EB_LSB +: 2]; // R13
                end
                if (wstrb_q[1]) out_en_q <= wdata_q[tec_pkg::OUT_EN_BIT];
            end else if (awaddr_q == tec_pkg::OFF_CAPCTL) begin
                if (wstrb_q[0]) begin
                    reg_a_capture_select_q <= wdata_q[tec_pkg::CAP_SEL_BIT]; // R7
                    capture_source_select_q <= wdata_q[tec_pkg::CAP_SRC_BIT]; // R10
                end
            end
        end
    end

    // Write channel: address and data in either order, then one response.
    assign s_axi_awready = (wstate_q == TEC_W_IDLE) && !aw_got_q;
    assign s_axi_wready = (wstate_q == TEC_W_IDLE) && !w_got_q;
    assign do_write = (wstate_q == TEC_W_IDLE) && aw_got_q && w_got_q;
    assign s_axi_bvalid = (wstate_q == TEC_W_RESP);
    assign s_axi_bresp = bresp_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wstate_q <= TEC_W_IDLE;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= 4'h0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bresp_q <= tec_pkg::RESP_OKAY;
        end else begin
            case (wstate_q)
                TEC_W_IDLE: begin
                    if (s_axi_awvalid && s_axi_awready) begin
                        aw_got_q <= 1'b1;
                        awaddr_q <= s_axi_awaddr;
                    end
                    if (s_axi_wvalid && s_axi_wready) begin
                        w_got_q <= 1'b1;
                        wdata_q <= s_axi_wdata;
                        wstrb_q <= s_axi_wstrb;
                    end
                    if (do_write) begin
                        wstate_q <= TEC_W_RESP;
                        aw_got_q <= 1'b0;
                        w_got_q <= 1'b0;
                        if (awaddr_q == tec_pkg::OFF_CMPA || awaddr_q == tec_pkg::OFF_MODE
                            || awaddr_q == tec_pkg::OFF_CAPCTL) begin
                            bresp_q <= tec_pkg::RESP_OKAY;
                        end else begin
                            bresp_q <= tec_pkg::RESP_SLVERR;
                        end
                    end
                end
                default: begin
                    if (s_axi_bready) wstate_q <= TEC_W_IDLE;
                end
            endcase
        end
    end

    // Read decode; the counter word is the live count, held in the read data register when the address is taken.
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_ok = 1'b1;
        if (s_axi_araddr == tec_pkg::OFF_COUNT) begin
            rd_word = {16'h0000, up_counter_q}; // R1
        end else if (s_axi_araddr == tec_pkg::OFF_CMPA) begin
            rd_word = {16'h0000, capture_compare_reg_a_q};
        end else if (s_axi_araddr == tec_pkg::OFF_MODE) begin
            rd_word = {23'h000000, out_en_q, edge_b_q, edge_a_q, run_mode_q, 2'h0};
        end else if (s_axi_araddr == tec_pkg::OFF_CAPCTL) begin
            rd_word = {30'h00000000, capture_source_select_q, reg_a_capture_select_q};
        end else begin
            rd_ok = 1'b0;
        end
    end

    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // Read response registered one cycle after the address is taken.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= tec_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= rd_ok ? tec_pkg::RESP_OKAY : tec_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // Checks next to the logic they guard.
    sequence stop_seen;
        run_mode_q == tec_pkg::RUN_STOP;
    endsequence

    sequence b_rise_seen;
        reg_a_capture_select_q && !capture_source_select_q && edge_b_q == tec_pkg::EDGE_RISE && pin_b.rise;
    endsequence

    sequence a_rev_fall_seen;
        reg_a_capture_select_q && capture_source_select_q && edge_a_q == tec_pkg::EDGE_RISE && pin_a.fall;
    endsequence

    stop_clears_a: assert property (@(posedge aclk) disable iff (!aresetn) // R4
        stop_seen |=> up_counter_q == tec_pkg::COUNT_RST) else $error("Counter not zero in stop.");
    count_step_a: assert property (@(posedge aclk) disable iff (!aresetn) // R1
        (run_mode_q == tec_pkg::RUN_FREE && $past(run_mode_q) == tec_pkg::RUN_FREE)
        |-> up_counter_q == $past(up_counter_q) + 16'h0001) else $error("Counter missed a step.");
    edge_clear_a: assert property (@(posedge aclk) disable iff (!aresetn) // R5
        (run_mode_q == tec_pkg::RUN_CLR_EDGE && valid_a) |=> up_counter_q == tec_pkg::COUNT_RST)
        else $error("Edge did not clear counter.");
    match_clear_a: assert property (@(posedge aclk) disable iff (!aresetn) // R6
        (run_mode_q == tec_pkg::RUN_CLR_MATCH && up_counter_q == capture_compare_reg_a_q)
        |=> up_counter_q == tec_pkg::COUNT_RST) else $error("Match did not clear counter.");
    match_irq_a: assert property (@(posedge aclk) disable iff (!aresetn) // R8
        match |=> match_a_interrupt) else $error("Match gave no interrupt.");
    capture_value_a: assert property (@(posedge aclk) disable iff (!aresetn) // R20
        trig |=> capture_compare_reg_a_q == $past(up_counter_q)) else $error("Capture value wrong.");
    both_nocap_a: assert property (@(posedge aclk) disable iff (!aresetn) // R11
        (capture_source_select_q && edge_a_q == tec_pkg::EDGE_BOTH) |-> !trig)
        else $error("Capture on both-edge input a.");
    snap_read_a: assert property (@(posedge aclk) disable iff (!aresetn) // R2
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == tec_pkg::OFF_COUNT)
        |=> s_axi_rdata == {16'h0000, snap_q}) else $error("Counter read not snapshot.");
    toggle_a: assert property (@(posedge aclk) disable iff (!aresetn) // R16
        (match && run_mode_q != tec_pkg::RUN_STOP) |=> timer_output != $past(timer_output))
        else $error("Output did not toggle.");
    // Reset is checked without the disable so that the clear it causes is seen.
    reset_zero_a: assert property (@(posedge aclk) // R3
        !aresetn |=> up_counter_q == tec_pkg::COUNT_RST) else $error("Reset left counter nonzero.");
    cap_b_rise_a: assert property (@(posedge aclk) disable iff (!aresetn) // R12
        b_rise_seen |=> capture_compare_reg_a_q == $past(up_counter_q)) else $error("Input b rise not captured.");
    cap_a_rev_a: assert property (@(posedge aclk) disable iff (!aresetn) // R11
        a_rev_fall_seen |=> capture_compare_reg_a_q == $past(up_counter_q))
        else $error("Input a reverse edge not captured.");
endmodule
